// [verilog/snv_mem_end.sv]
`timescale 1ns/1ps
`include "snv_defines.svh"
module snv_mem_end
   import snv_pkg::*;
#(
   parameter int DEPTH = `SNV_DEPTH
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   snv_link_if.mem         link,
   output logic            cmdValid,
   output logic [7:0]      cmdOpcode,
   output logic [7:0]      statusOut
);
   // link inputs pass two flops before any logic reads them
   typedef struct packed {
      logic [1:0]            csS;
      logic [1:0]            sckS;
      logic [1:0]            mosiS;
      logic                  sckD;
      logic                  selected;
      logic                  modeThree;
      logic                  armed;
      snv_phase_e            phase;
      logic [2:0]            bitCnt;
      logic [7:0]            shiftIn;
      logic [7:0]            opcode;
      logic [1:0]            addrCnt;
      logic [23:0]           addr;
      logic [7:0]            shiftOut;
      logic                  miso;
      logic                  misoOe;
      logic [7:0]            status;
      logic                  wrEn;
      logic [`SNV_ADDR_W-1:0] wrAddr;
      logic [7:0]            wrData;
      logic                  cmdValid;
   } snv_mem_s;
   snv_mem_s s_r, s_nxt;
   logic [7:0] mem [DEPTH];
   logic [7:0] rdByte;
   logic       csN, sck, mosi, rise, fall;
   logic [7:0] byteIn;
   logic       validOp;
   assign csN    = s_r.csS[1];
   assign sck    = s_r.sckS[1];
   assign mosi   = s_r.mosiS[1];
   // edges come from the oversampled level: each sck half period must last at least
   // four mclk, which bounds the link rate by the local clock
   assign rise   = sck && !s_r.sckD;
   assign fall   = !sck && s_r.sckD;
   assign byteIn = {s_r.shiftIn[6:0], mosi};
   assign rdByte = mem[s_r.addr[`SNV_ADDR_W-1:0]];
   // anything outside the thirteen codes sends the frame to the dead phase
   always_comb begin
      unique case (byteIn)
         `SNV_OP_RDSTAT, `SNV_OP_WRSTAT, `SNV_OP_WRITE, `SNV_OP_READ, `SNV_OP_FREAD,
         `SNV_OP_SSWR, `SNV_OP_SSRD, `SNV_OP_RDID, `SNV_OP_RUID, `SNV_OP_WRSN,
         `SNV_OP_RDSN, `SNV_OP_DPD, `SNV_OP_HBN: validOp = 1'b1;
         default: validOp = 1'b0;
      endcase
   end
   always_comb begin
      s_nxt          = s_r;
      s_nxt.csS      = {s_r.csS[0], link.csN};
      s_nxt.sckS     = {s_r.sckS[0], link.sck};
      s_nxt.mosiS    = {s_r.mosiS[0], link.mosi};
      s_nxt.sckD     = sck;
      s_nxt.wrEn     = 1'b0;
      s_nxt.cmdValid = 1'b0;
      if (csN) begin
         // deselect clears framing so the next select starts at the opcode
         s_nxt.selected = 1'b0;
         s_nxt.phase    = SNV_OPCODE;
         s_nxt.bitCnt   = '0;
         s_nxt.addrCnt  = '0;
         s_nxt.misoOe   = 1'b0;
         s_nxt.miso     = 1'b0;
         s_nxt.armed    = 1'b0;
         s_nxt.shiftIn  = '0;
      end else if (!s_r.selected) begin
         s_nxt.selected  = 1'b1;
         // sck passes the same two flops as the select, so this is its level at the fall
         s_nxt.modeThree = sck;
         // idle-high sck is no edge: only a rise after the first fall counts
         s_nxt.armed     = !sck;
      end else begin
         if (fall) begin
            s_nxt.armed = 1'b1;
         end
         if (rise && s_r.armed && s_r.phase != SNV_DEAD && s_r.phase != SNV_DONE) begin
            s_nxt.shiftIn = byteIn;
            s_nxt.bitCnt  = s_r.bitCnt + 3'd1;
            if (s_r.bitCnt == 3'd7) begin
               unique case (s_r.phase)
                  SNV_OPCODE: begin
                     s_nxt.opcode   = byteIn;
                     s_nxt.cmdValid = validOp;
                     if (!validOp) begin
                        s_nxt.phase = SNV_DEAD;
                     end else if (byteIn == `SNV_OP_RDSTAT) begin
                        s_nxt.phase    = SNV_STATR;
                        s_nxt.shiftOut = s_r.status;
                     end else if (byteIn == `SNV_OP_WRSTAT) begin
                        s_nxt.phase = SNV_STATW;
                     end else if (byteIn == `SNV_OP_READ || byteIn == `SNV_OP_WRITE) begin
                        s_nxt.phase = SNV_ADDR;
                     end else begin
                        s_nxt.phase = SNV_DONE;
                     end
                  end
                  SNV_ADDR: begin
                     s_nxt.addr    = {s_r.addr[15:0], byteIn};
                     s_nxt.addrCnt = s_r.addrCnt + 2'd1;
                     if (s_r.addrCnt == 2'(`SNV_ADDR_BYTES - 1)) begin
                        if (s_r.opcode == `SNV_OP_READ) begin
                           s_nxt.phase    = SNV_RDATA;
                           s_nxt.shiftOut = mem[byteIn | {s_r.addr[9:0], 8'h00}];
                        end else begin
                           s_nxt.phase = SNV_WDATA;
                        end
                     end
                  end
                  // committed from registers one mclk later, well before a new select is seen
                  SNV_WDATA: begin
                     s_nxt.wrEn   = 1'b1;
                     s_nxt.wrAddr = s_r.addr[`SNV_ADDR_W-1:0];
                     s_nxt.wrData = byteIn;
                     s_nxt.addr   = s_r.addr + 24'd1;
                  end
                  // only the protect bits take the written value; bits 6 and 1 stay one
                  SNV_STATW: begin
                     s_nxt.status = (byteIn & `SNV_STAT_WMASK) | `SNV_STAT_FIXED1;
                     s_nxt.phase  = SNV_DONE;
                  end
                  SNV_RDATA: begin
                     s_nxt.addr = s_r.addr + 24'd1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         if (fall && (s_r.phase == SNV_RDATA || s_r.phase == SNV_STATR)) begin
            s_nxt.misoOe = 1'b1;
            // a new byte starts: its first bit comes straight from the array, or from the status register in a status read
            if (s_r.bitCnt == 3'd0) begin
               s_nxt.miso     = s_r.shiftOut[7];
               s_nxt.shiftOut = (s_r.phase == SNV_RDATA) ? {rdByte[6:0], 1'b0}
                                                          : {s_r.status[6:0], 1'b0};
               if (s_r.phase == SNV_RDATA) begin
                  s_nxt.miso = rdByte[7];
               end else begin
                  s_nxt.miso = s_r.status[7];
               end
            end else begin
               s_nxt.miso     = s_r.shiftOut[7];
               s_nxt.shiftOut = {s_r.shiftOut[6:0], 1'b0};
            end
         end
         // a rejected opcode leaves the output released until the next select
         if (s_r.phase == SNV_DEAD) begin
            s_nxt.misoOe = 1'b0;
         end
      end
   end
   // the array has no reset: a byte never written reads back unknown
   always_ff @(posedge mclk) begin
      if (s_r.wrEn) begin
         mem[s_r.wrAddr] <= s_r.wrData;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_r        <= '0;
         s_r.csS    <= 2'b11;
         s_r.phase  <= SNV_OPCODE;
         s_r.status <= `SNV_STAT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign link.miso   = s_r.miso;
   assign link.misoOe = s_r.misoOe;
   assign cmdValid    = s_r.cmdValid;
   assign cmdOpcode   = s_r.opcode;
   assign statusOut   = s_r.status;
endmodule // snv_mem_end

// [verilog/snv_defines.svh]
`ifndef SNV_DEFINES_SVH
`define SNV_DEFINES_SVH
`define SNV_ADDR_W        18
`define SNV_ADDR_BYTES    3
`define SNV_DEPTH         262144
`define SNV_OP_RDSTAT     8'h05
`define SNV_OP_WRSTAT     8'h01
`define SNV_OP_WRITE      8'h02
`define SNV_OP_READ       8'h03
`define SNV_OP_FREAD      8'h0b
`define SNV_OP_SSWR       8'h42
`define SNV_OP_SSRD       8'h4b
`define SNV_OP_RDID       8'h9f
`define SNV_OP_RUID       8'h4c
`define SNV_OP_WRSN       8'hc2
`define SNV_OP_RDSN       8'hc3
`define SNV_OP_DPD        8'hba
`define SNV_OP_HBN        8'hb9
`define SNV_STAT_RST      8'h42
`define SNV_STAT_WMASK    8'h8c
`define SNV_STAT_FIXED1   8'h42
`define SNV_SCK_MAX_MHZ   50
`define SNV_PU_DELAY_NS   1000
`define SNV_CLK_MHZ       200
`define SNV_PU_CYC        ((`SNV_PU_DELAY_NS * `SNV_CLK_MHZ + 999) / 1000)
`define SNV_SCK_DIV       ((`SNV_CLK_MHZ + 2 * `SNV_SCK_MAX_MHZ - 1) / (2 * `SNV_SCK_MAX_MHZ))
`endif

// [verilog/snv_pkg.sv]
package snv_pkg;
   typedef enum logic [2:0] {SNV_OPCODE, SNV_ADDR, SNV_WDATA, SNV_RDATA, SNV_STATW,
                             SNV_STATR, SNV_DEAD, SNV_DONE} snv_phase_e;
   typedef enum logic [2:0] {SNM_IDLE, SNM_PUWAIT, SNM_SEL, SNM_LOW, SNM_HIGH,
                             SNM_DESEL} snv_mstate_e;
   typedef enum logic [1:0] {SNV_CMD_READ, SNV_CMD_WRITE, SNV_CMD_RDSTAT,
                             SNV_CMD_WRSTAT} snv_cmd_e;
endpackage

// [verilog/snv_link_if.sv]
`timescale 1ns/1ps
interface snv_link_if;
   logic csN;
   logic sck;
   logic mosi;
   logic miso;
   logic misoOe;
   modport mem (input csN, input sck, input mosi, output miso, output misoOe);
   modport mst (output csN, output sck, output mosi, input miso, input misoOe);
endinterface

// [verilog/snv_fifo.sv]
`timescale 1ns/1ps
module snv_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic [AW:0]      count;
   assign count    = wrPtr_r - rdPtr_r;
   assign inReady  = count != (AW+1)'(DEPTH);
   assign outValid = count != '0;
   assign outData  = mem[rdPtr_r[AW-1:0]];
   always_ff @(posedge mclk) begin
      if (inValid && inReady) begin
         mem[wrPtr_r[AW-1:0]] <= inData;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (inValid && inReady) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (outValid && outReady) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule // snv_fifo

// [verilog/snv_master_end.sv]
`timescale 1ns/1ps
`include "snv_defines.svh"
module snv_master_end
   import snv_pkg::*;
#(
   parameter int PU_CYC = `SNV_PU_CYC,
   parameter int DIV    = `SNV_SCK_DIV
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   snv_link_if.mst          link,
   input  wire logic        modeThree,
   input  wire logic [1:0]  reqCmd,
   input  wire logic [17:0] reqAddr,
   input  wire logic [7:0]  reqLen,
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic [7:0]  wrData,
   input  wire logic        wrValid,
   output logic             wrReady,
   output logic [7:0]       rdData,
   output logic             rdValid,
   input  wire logic        rdReady
);
   typedef struct packed {
      snv_mstate_e st;
      logic [15:0] puCnt;
      logic [7:0]  divCnt;
      logic        sck;
      logic        csN;
      logic        mosi;
      logic [1:0]  misoS;
      logic        modeThree;
      logic [39:0] txSr;
      logic [7:0]  rxSr;
      logic [5:0]  bitCnt;
      logic [7:0]  bytesLeft;
      logic [1:0]  cmd;
      logic        hdr;
      logic        push;
      logic [7:0]  pushData;
   } snv_mst_s;
   snv_mst_s m_r, m_nxt;
   logic       fInReady;
   logic       divHit;
   logic [7:0] opc;
   assign divHit = m_r.divCnt == 8'(DIV - 1);
   always_comb begin
      unique case (snv_cmd_e'(reqCmd))
         SNV_CMD_READ:   opc = `SNV_OP_READ;
         SNV_CMD_WRITE:  opc = `SNV_OP_WRITE;
         SNV_CMD_RDSTAT: opc = `SNV_OP_RDSTAT;
         default:        opc = `SNV_OP_WRSTAT;
      endcase
   end
   assign reqReady = m_r.st == SNM_IDLE;
   // data byte is acknowledged after the first bit of the byte it fills, and only if another byte still follows
   assign wrReady = m_r.st == SNM_HIGH && divHit && m_r.bitCnt[2:0] == 3'd7 && !m_r.hdr
                    && m_r.bytesLeft > 8'd1 && m_r.cmd == 2'(SNV_CMD_WRITE);
   always_comb begin
      m_nxt        = m_r;
      m_nxt.misoS  = {m_r.misoS[0], link.miso};
      m_nxt.push   = 1'b0;
      m_nxt.divCnt = divHit ? 8'd0 : m_r.divCnt + 8'd1;
      unique case (m_r.st)
         SNM_PUWAIT: begin
            if (m_r.puCnt == 16'(PU_CYC)) begin
               m_nxt.st = SNM_IDLE;
            end else begin
               m_nxt.puCnt = m_r.puCnt + 16'd1;
            end
            m_nxt.sck = modeThree;
         end
         SNM_IDLE: begin
            m_nxt.sck = modeThree;
            if (reqValid) begin
               m_nxt.modeThree = modeThree;
               m_nxt.cmd       = reqCmd;
               m_nxt.txSr      = {opc, 6'b000000, reqAddr, 8'h00};
               m_nxt.bitCnt    = (reqCmd[1]) ? 6'd7 : 6'd31;
               m_nxt.hdr       = 1'b1;
               m_nxt.bytesLeft = (reqLen == 8'd0) ? 8'd1 : reqLen;
               m_nxt.csN       = 1'b0;
               m_nxt.divCnt    = 8'd0;
               m_nxt.st        = SNM_SEL;
            end
         end
         SNM_SEL: begin
            if (divHit) begin
               if (m_r.modeThree) begin
                  m_nxt.sck = 1'b0;
               end
               m_nxt.mosi = m_r.txSr[39];
               m_nxt.st   = SNM_LOW;
            end
         end
         SNM_LOW: begin
            if (divHit && fInReady) begin
               m_nxt.sck  = 1'b1;
               m_nxt.rxSr = {m_r.rxSr[6:0], m_r.misoS[1]};
               m_nxt.st   = SNM_HIGH;
            end
         end
         SNM_HIGH: begin
            if (divHit) begin
               m_nxt.sck    = 1'b0;
               m_nxt.txSr   = {m_r.txSr[38:0], 1'b0};
               m_nxt.bitCnt = m_r.bitCnt - 6'd1;
               m_nxt.st     = SNM_LOW;
               if (m_r.bitCnt[2:0] == 3'd0 && !m_r.hdr) begin
                  m_nxt.push      = m_r.cmd != 2'(SNV_CMD_WRITE) && m_r.cmd != 2'(SNV_CMD_WRSTAT);
                  m_nxt.pushData  = m_r.rxSr;
                  m_nxt.bytesLeft = m_r.bytesLeft - 8'd1;
               end
               if (m_r.bitCnt == 6'd0) begin
                  m_nxt.hdr    = 1'b0;
                  m_nxt.bitCnt = 6'd7;
                  m_nxt.txSr   = {wrData, 32'h0};
                  if (!m_r.hdr && m_r.bytesLeft == 8'd1) begin
                     m_nxt.st  = SNM_DESEL;
                     m_nxt.sck = m_r.modeThree;
                  end else if (m_r.cmd[0] && !(m_r.cmd == 2'(SNV_CMD_WRITE) && !m_r.hdr
                               ? wrValid : 1'b1)) begin
                     m_nxt.txSr = {8'h00, 32'h0};
                  end
               end
               // mode 3 ends with sck parked high, so the data line must hold still there
               if (m_nxt.st != SNM_DESEL) begin
                  m_nxt.mosi = m_nxt.txSr[39];
               end
            end
         end
         default: begin
            if (divHit) begin
               m_nxt.csN = 1'b1;
               m_nxt.st  = SNM_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         m_r     <= '0;
         m_r.csN <= 1'b1;
         m_r.st  <= SNM_PUWAIT;
      end else begin
         m_r <= m_nxt;
      end
   end
   snv_fifo #(.WIDTH(8), .DEPTH(4)) u_rxfifo (
      .mclk     (mclk),
      .rst      (rst),
      .inData   (m_r.pushData),
      .inValid  (m_r.push),
      .inReady  (fInReady),
      .outData  (rdData),
      .outValid (rdValid),
      .outReady (rdReady)
   );
   assign link.csN  = m_r.csN;
   assign link.sck  = m_r.sck;
   assign link.mosi = m_r.mosi;
endmodule // snv_master_end

// [verification/snv_link_checker.sv]
`timescale 1ns/1ps
module snv_link_checker #(
   parameter int PU_CYC = 10
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic misoOe
);
   int puCnt;
   // saturating count of cycles since reset, for the power-up hold-off
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         puCnt <= 0;
      end else if (puCnt < PU_CYC) begin
         puCnt <= puCnt + 1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_release; csN [*4] |-> !misoOe; endproperty
   a_release: assert property (p_release)
      else $error("miso driven while deselected");
   property p_so_fall; $changed(miso) && misoOe && $past(misoOe) |-> !sck; endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("miso moved while sck high");
   property p_pu; !csN |-> puCnt == PU_CYC; endproperty
   a_pu: assert property (p_pu)
      else $error("select before power-up delay");
   property p_rate; $changed(sck) |=> $stable(sck) [*3]; endproperty
   a_rate: assert property (p_rate)
      else $error("sck half period too short");
   property p_mode; $fell(csN) |-> $stable(sck) [*2]; endproperty
   a_mode: assert property (p_mode)
      else $error("sck moved at select");
   property p_park; $rose(csN) |-> $stable(sck) [*2]; endproperty
   a_park: assert property (p_park)
      else $error("sck not parked at deselect");
   property p_si; $changed(mosi) && !csN && !$past(csN) |-> !sck; endproperty
   a_si: assert property (p_si)
      else $error("mosi moved while sck high");
   property p_oe; $rose(misoOe) |-> !csN && !sck; endproperty
   a_oe: assert property (p_oe)
      else $error("miso enabled off a falling edge");
endmodule // snv_link_checker

// [verification/testbench.sv]
`timescale 1ns/1ps
`include "snv_defines.svh"
module testbench;
   import snv_pkg::*;
   logic       mclk;
   logic       rst;
   logic       modeThree;
   logic       reqValid;
   logic       wrValid;
   logic       rdReady;
   logic [1:0] reqCmd;
   logic [17:0] reqAddr;
   logic [7:0] reqLen;
   logic [7:0] wrData;
   logic       reqReady;
   logic       wrReady;
   logic       rdValid;
   logic       cmdValid;
   logic [7:0] rdData;
   logic [7:0] cmdOpcode;
   logic [7:0] statusOut;
   int         bad_count;
   int         n_checks;
   int         nCmd = 0;
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   snv_link_if link();
   snv_master_end #(.PU_CYC(10), .DIV(16)) i_snv_master_end (
      .mclk(mclk), .rst(rst), .link(link), .modeThree(modeThree),
      .reqCmd(reqCmd), .reqAddr(reqAddr), .reqLen(reqLen), .reqValid(reqValid),
      .reqReady(reqReady), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
      .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady));
   snv_mem_end i_snv_mem_end (
      .mclk(mclk), .rst(rst), .link(link), .cmdValid(cmdValid),
      .cmdOpcode(cmdOpcode), .statusOut(statusOut));
   snv_link_checker #(.PU_CYC(10)) i_snv_link_checker (
      .mclk(mclk), .rst(rst), .csN(link.csN), .sck(link.sck), .mosi(link.mosi),
      .miso(link.miso), .misoOe(link.misoOe));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (cmdValid === 1'b1) nCmd <= nCmd + 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // one whole frame: write bytes come from wq, expected read bytes from rq;
   // rdReady is held low for hold cycles so the fifo fills and sck stalls
   task automatic xfer(input logic [1:0] cmd, input logic [17:0] addr, input int hold);
      int   k;
      int   w;
      int   r;
      int   rise;
      int   n0;
      logic sPrev;
      logic adv;
      int   nBits;
      w = 0;
      r = 0;
      rise = 0;
      adv = 1'b0;
      n0 = nCmd;
      @(negedge mclk);
      sPrev = link.sck;
      reqCmd = cmd;
      reqAddr = addr;
      reqLen = (wq.size() > 0) ? 8'(wq.size()) : 8'(rq.size());
      wrData = (wq.size() > 0) ? wq[0] : 8'h00;
      wrValid = (wq.size() > 0);
      rdReady = 1'b0;
      reqValid = 1'b1;
      for (k = 0; reqReady !== 1'b1; k++) begin
         if (k > 500) begin
            bad_count++;
            report_and_stop;
         end
         @(negedge mclk);
      end
      @(negedge mclk);
      reqValid = 1'b0;
      k = 0;
      while (!(link.csN === 1'b1 && k > 8 && r == rq.size())) begin
         @(negedge mclk);
         k++;
         if (k > 20000) begin
            bad_count++;
            report_and_stop;
         end
         if (adv) begin
            w++;
            wrData = (w < wq.size()) ? wq[w] : 8'h00;
            adv = 1'b0;
         end
         if (link.sck === 1'b1 && sPrev === 1'b0) rise++;
         sPrev = link.sck;
         if (wrReady === 1'b1) adv = 1'b1;
         if (hold > 0 && k == hold) chk({7'h00, link.csN}, 8'h00);
         rdReady = (k > hold);
         if (rdValid === 1'b1 && rdReady === 1'b1 && r < rq.size()) begin
            chk(rdData, rq[r]);
            r++;
         end
      end
      wrValid = 1'b0;
      nBits = (cmd[1] ? 8 : 32) + 8 * int'(reqLen);
      chk(8'(rise), 8'(nBits));
      chk(8'(nCmd - n0), 8'h01);
      wq.delete();
      rq.delete();
   endtask
   task automatic t_reset;
      chk(statusOut, `SNV_STAT_RST);
      chk({7'h00, link.misoOe}, 8'h00);
   endtask
   task automatic t_mode0;
      modeThree = 1'b0;
      wq = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
      xfer(2'd1, 18'h3fffc, 0);
      chk(cmdOpcode, `SNV_OP_WRITE);
      rq = '{8'h5a, 8'hc3, 8'h3c};
      xfer(2'd0, 18'h3fffd, 0);
      chk(cmdOpcode, `SNV_OP_READ);
   endtask
   task automatic t_mode3;
      @(negedge mclk);
      modeThree = 1'b1;
      repeat (40) @(negedge mclk);
      wq = '{8'h96, 8'h69};
      xfer(2'd1, 18'h00000, 0);
      rq = '{8'h69};
      xfer(2'd0, 18'h00001, 0);
      rq = '{8'ha5};
      xfer(2'd0, 18'h3fffc, 0);
   endtask
   task automatic t_fifo;
      @(negedge mclk);
      modeThree = 1'b0;
      repeat (40) @(negedge mclk);
      wq = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
      xfer(2'd1, 18'h01000, 0);
      rq = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
      xfer(2'd0, 18'h01000, 4000);
   endtask
   task automatic t_status;
      logic [7:0] exp;
      exp = (8'hff & `SNV_STAT_WMASK) | `SNV_STAT_FIXED1;
      wq = '{8'hff};
      xfer(2'd3, 18'h00000, 0);
      chk(statusOut, exp);
      rq = '{exp};
      xfer(2'd2, 18'h00000, 0);
      chk(cmdOpcode, `SNV_OP_RDSTAT);
      wq = '{8'h00};
      xfer(2'd3, 18'h00000, 0);
      chk(statusOut, `SNV_STAT_FIXED1);
      chk(cmdOpcode, `SNV_OP_WRSTAT);
   endtask
   initial begin
      rst = 1'b1;
      modeThree = 1'b0;
      reqValid = 1'b0;
      reqCmd = 2'd0;
      reqAddr = 18'h00000;
      reqLen = 8'h00;
      wrData = 8'h00;
      wrValid = 1'b0;
      rdReady = 1'b0;
      bad_count = 0;
      n_checks = 0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      t_reset;
      t_mode0;
      t_mode3;
      t_fifo;
      t_status;
      report_and_stop;
   end
endmodule // testbench
